/* logic/flash_self_program_control.v */
// Flash self-programming controller: APB registers, page write buffer,
// page erase, page write and single-word read towards the flash array.
// Assumes an APB master on CORE_CLK and a flash array answering on the
// same clock with a one-cycle FLASH_ACK per request.
//
// Overview of operation
// - Erase and write act on a whole page, a read moves one word.
// - The page and the write buffer both hold thirty-two words.
// - The erase/write enabled flag rises only after the key procedure succeeds.
// - Data enters the write buffer only while that flag is high.
// - Software sets the write start flag; it shows busy until hardware clears it.
// - Reads need the read permit bit, then the read start flag launches and shows one read.
// - Hardware clears the read start flag when the read is finished.
// - Page is high address with low bits 7..5; low bits 4..0 pick the word.
// - Writing the high data byte loads both data bytes as one word and bumps the address.
// - At the last word of a page the address no longer increments.
// - Software sets the clear buffer request; hardware clears it when done.
// - The buffer is cleared automatically after a write.
`include "flash_selfprog_defs.vh"

module flash_self_program_control #(
   parameter WORDS  = 32,
   parameter IDX_W  = 5,
   parameter ADDR_W = 13
) (
   input  wire              CORE_CLK,
   input  wire              RST_B,
   input  wire              PSEL,
   input  wire              PENABLE,
   input  wire              PWRITE,
   input  wire [7:0]        PADDR,
   input  wire [31:0]       PWDATA,
   output reg  [31:0]       PRDATA,
   output reg               PREADY,
   output reg               PSLVERR,
   output reg               FLASH_REQ,
   output reg  [1:0]        FLASH_OP,
   output reg  [ADDR_W-1:0] FLASH_ADDR,
   output reg  [15:0]       FLASH_WDATA,
   input  wire              FLASH_ACK,
   input  wire [15:0]       FLASH_RDATA,
   output wire              IRQ
);

   localparam [1:0] ST_IDLE  = 2'd0;
   localparam [1:0] ST_ERASE = 2'd1;
   localparam [1:0] ST_WRITE = 2'd2;
   localparam [1:0] ST_READ  = 2'd3;

   reg  [1:0]        state_q;
   reg               ew_enabled_q;
   reg  [2:0]        mode_q;
   reg               write_prot_q;
   reg               write_go_q;
   reg               read_perm_q;
   reg               read_go_q;
   reg               erase_go_q;
   reg               clear_req_q;
   reg  [1:0]        key_step_q;
   reg  [7:0]        addr_low_q;
   reg  [4:0]        addr_high_q;
   reg  [7:0]        data_low_q;
   reg  [7:0]        data_high_q;
   reg  [15:0]       read_data_q;
   reg  [IDX_W-1:0]  widx_q;
   reg               clear_started_q;
   reg  [`EV_COUNT-1:0] ev_d;
   wire              wr_acc;
   wire              mapped;
   wire              busy;
   wire              load_ok;
   wire [IDX_W-1:0]  rd_idx;
   wire [15:0]       buf_word;
   wire              clear_busy;
   wire              auto_clear;
   wire [`EV_COUNT-1:0] irq_status;
   wire [`EV_COUNT-1:0] irq_mask;
   wire [7:0]        wb;
   wire [7:0]        page_no;

   // Address decode shared by the write accept and the error flag
   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a == `OFS_CTRL) || (a == `OFS_KEY) || (a == `OFS_CTRL2) ||
                     (a == `OFS_ADDR_LOW) || (a == `OFS_ADDR_HIGH) ||
                     (a == `OFS_DATA_LOW) || (a == `OFS_DATA_HIGH) ||
                     (a == `OFS_READ_DATA) || (a == `OFS_IRQ_STATUS) ||
                     (a == `OFS_IRQ_MASK);
      end
   endfunction

   assign wb      = PWDATA[7:0];
   assign mapped  = is_mapped(PADDR);
   assign wr_acc  = PSEL && PENABLE && PREADY && PWRITE && mapped;
   assign busy    = (state_q != ST_IDLE) || clear_busy || clear_req_q;
   assign page_no = {addr_high_q, addr_low_q[7:5]};
   assign load_ok = wr_acc && PADDR == `OFS_DATA_HIGH && ew_enabled_q && !busy;

   // =================================================================
   // APB slave: no wait states, answer registered in the setup cycle
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
      end else begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !mapped;
         PRDATA  <= 32'h0000_0000;
         if (PSEL && !PENABLE && !PWRITE) begin
            if (PADDR == `OFS_CTRL) begin
               PRDATA[7:0] <= {ew_enabled_q, mode_q, write_prot_q,
                               write_go_q, read_perm_q, read_go_q};
            end else if (PADDR == `OFS_CTRL2) begin
               PRDATA[1:0] <= {erase_go_q, clear_req_q};
            end else if (PADDR == `OFS_ADDR_LOW) begin
               PRDATA[7:0] <= addr_low_q;
            end else if (PADDR == `OFS_ADDR_HIGH) begin
               PRDATA[4:0] <= addr_high_q;
            end else if (PADDR == `OFS_DATA_LOW) begin
               PRDATA[7:0] <= data_low_q;
            end else if (PADDR == `OFS_DATA_HIGH) begin
               PRDATA[7:0] <= data_high_q;
            end else if (PADDR == `OFS_READ_DATA) begin
               PRDATA[15:0] <= read_data_q;
            end else if (PADDR == `OFS_IRQ_STATUS) begin
               PRDATA[`EV_COUNT-1:0] <= irq_status;
            end else if (PADDR == `OFS_IRQ_MASK) begin
               PRDATA[`EV_COUNT-1:0] <= irq_mask;
            end
         end
      end
   end

   // =================================================================
   // Enable key procedure and control bits
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ew_enabled_q <= 1'b0;
         key_step_q   <= 2'd0;
         mode_q       <= 3'd0;
         write_prot_q <= 1'b0;
         read_perm_q  <= 1'b0;
      end else if (wr_acc && PADDR == `OFS_KEY) begin
         // A wrong value restarts the procedure so stray writes cannot unlock
         if (key_step_q == 2'd0 && wb == `KEY_FIRST) begin
            key_step_q <= 2'd1;
         end else if (key_step_q == 2'd1 && wb == `KEY_SECOND) begin
            key_step_q <= 2'd2;
         end else if (key_step_q == 2'd2 && wb == `KEY_THIRD) begin
            key_step_q   <= 2'd0;
            ew_enabled_q <= 1'b1;
         end else begin
            key_step_q <= 2'd0;
         end
      end else if (wr_acc && PADDR == `OFS_CTRL) begin
         mode_q       <= wb[`CTRL_MODE_HI:`CTRL_MODE_LO];
         write_prot_q <= wb[`CTRL_WRITE_PROT];
         read_perm_q  <= wb[`CTRL_READ_PERM];
         // Software may drop the enable; it can only be raised by the key
         if (!wb[`CTRL_EW_ENABLED]) begin
            ew_enabled_q <= 1'b0;
         end
      end
   end

   // =================================================================
   // Address and data registers; high byte write loads the buffer
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         addr_low_q  <= `RESET_BYTE;
         addr_high_q <= 5'h00;
         data_low_q  <= `RESET_BYTE;
         data_high_q <= `RESET_BYTE;
      end else if (wr_acc && PADDR == `OFS_ADDR_LOW && state_q == ST_IDLE) begin
         addr_low_q <= wb;
      end else if (wr_acc && PADDR == `OFS_ADDR_HIGH && state_q == ST_IDLE) begin
         addr_high_q <= wb[4:0];
      end else if (wr_acc && PADDR == `OFS_DATA_LOW) begin
         data_low_q <= wb;
      end else if (wr_acc && PADDR == `OFS_DATA_HIGH) begin
         data_high_q <= wb;
         if (load_ok && addr_low_q[4:0] != `WORD_OFS_LAST) begin
            addr_low_q <= addr_low_q + 8'h01;
         end
      end
   end

   // =================================================================
   // Operation sequencer towards the flash array
   assign auto_clear = state_q == ST_WRITE && FLASH_ACK &&
                       widx_q == WORDS[IDX_W-1:0] - 1'b1;
   assign rd_idx     = (state_q == ST_WRITE && FLASH_ACK) ? widx_q + 1'b1 : {IDX_W{1'b0}};

   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q     <= ST_IDLE;
         write_go_q  <= 1'b0;
         read_go_q   <= 1'b0;
         erase_go_q  <= 1'b0;
         widx_q      <= {IDX_W{1'b0}};
         FLASH_REQ   <= 1'b0;
         FLASH_OP    <= `OP_READ;
         FLASH_ADDR  <= {ADDR_W{1'b0}};
         FLASH_WDATA <= 16'h0000;
         read_data_q <= 16'h0000;
      end else begin
         case (state_q)
         ST_IDLE: begin
            // Only one start is honoured; starts written while busy are dropped
            if (wr_acc && PADDR == `OFS_CTRL && wb[`CTRL_WRITE_GO] &&
                ew_enabled_q && !busy) begin
               write_go_q  <= 1'b1;
               state_q     <= ST_WRITE;
               widx_q      <= {IDX_W{1'b0}};
               FLASH_REQ   <= 1'b1;
               FLASH_OP    <= `OP_WRITE;
               FLASH_ADDR  <= {page_no, {IDX_W{1'b0}}};
               FLASH_WDATA <= buf_word;
            end else if (wr_acc && PADDR == `OFS_CTRL && wb[`CTRL_READ_GO] &&
                         wb[`CTRL_READ_PERM] && read_perm_q && !busy) begin
               read_go_q  <= 1'b1;
               state_q    <= ST_READ;
               FLASH_REQ  <= 1'b1;
               FLASH_OP   <= `OP_READ;
               FLASH_ADDR <= {page_no, addr_low_q[4:0]};
            end else if (wr_acc && PADDR == `OFS_CTRL2 && wb[`CTRL2_ERASE_GO] &&
                         ew_enabled_q && !busy) begin
               erase_go_q <= 1'b1;
               state_q    <= ST_ERASE;
               FLASH_REQ  <= 1'b1;
               FLASH_OP   <= `OP_ERASE;
               FLASH_ADDR <= {page_no, {IDX_W{1'b0}}};
            end
         end
         ST_ERASE: begin
            if (FLASH_ACK) begin
               FLASH_REQ  <= 1'b0;
               erase_go_q <= 1'b0;
               state_q    <= ST_IDLE;
            end
         end
         ST_WRITE: begin
            // All thirty-two words go out; unloaded ones carry the erased value
            if (FLASH_ACK) begin
               if (auto_clear) begin
                  FLASH_REQ  <= 1'b0;
                  write_go_q <= 1'b0;
                  state_q    <= ST_IDLE;
               end else begin
                  widx_q      <= widx_q + 1'b1;
                  FLASH_ADDR  <= {page_no, rd_idx};
                  FLASH_WDATA <= buf_word;
               end
            end
         end
         ST_READ: begin
            if (FLASH_ACK) begin
               FLASH_REQ   <= 1'b0;
               read_data_q <= FLASH_RDATA;
               read_go_q   <= 1'b0;
               state_q     <= ST_IDLE;
            end
         end
         default: begin
            state_q <= ST_IDLE;
         end
         endcase
      end
   end

   // =================================================================
   // Clear buffer request, held until the walk finishes
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         clear_req_q     <= 1'b0;
         clear_started_q <= 1'b0;
      end else if (clear_req_q) begin
         clear_started_q <= 1'b1;
         if (clear_started_q && !clear_busy) begin
            clear_req_q     <= 1'b0;
            clear_started_q <= 1'b0;
         end
      end else if (wr_acc && PADDR == `OFS_CTRL2 && wb[`CTRL2_CLEAR_BUF] &&
                   state_q == ST_IDLE && !clear_busy) begin
         clear_req_q <= 1'b1;
      end
   end

   page_write_buffer #(
      .WIDTH       (16),
      .DEPTH       (WORDS),
      .IDX_W       (IDX_W)
   ) u_buffer (
      .clk         (CORE_CLK),
      .rst_b       (RST_B),
      .load        (load_ok),
      .load_idx    (addr_low_q[4:0]),
      .load_data   ({wb, data_low_q}),
      .clear_start ((clear_req_q && !clear_started_q) || auto_clear),
      .rd_idx      (rd_idx),
      .rd_data     (buf_word),
      .clear_busy  (clear_busy)
   );

   // =================================================================
   // Interrupt events
   always @* begin
      ev_d = {`EV_COUNT{1'b0}};
      ev_d[`EV_WRITE_DONE]   = auto_clear;
      ev_d[`EV_READ_DONE]    = state_q == ST_READ && FLASH_ACK;
      ev_d[`EV_ERASE_DONE]   = state_q == ST_ERASE && FLASH_ACK;
      ev_d[`EV_LOAD_REFUSED] = wr_acc && PADDR == `OFS_DATA_HIGH && !load_ok;
   end

   event_irq #(
      .N          (`EV_COUNT)
   ) u_irq (
      .clk        (CORE_CLK),
      .rst_b      (RST_B),
      .event_set  (ev_d),
      .clear_ones ((wr_acc && PADDR == `OFS_IRQ_STATUS) ? wb[`EV_COUNT-1:0]
                                                          : {`EV_COUNT{1'b0}}),
      .mask_we    (wr_acc && PADDR == `OFS_IRQ_MASK),
      .mask_wdata (wb[`EV_COUNT-1:0]),
      .status_q   (irq_status),
      .mask_q     (irq_mask),
      .irq_q      (IRQ)
   );

endmodule // flash_self_program_control

/* logic/flash_selfprog_defs.vh */
// Constants for the flash self-programming controller: APB offsets,
// field positions, reset values and flash operation codes.
// Assumes inclusion by bare name from the logic/ directory.
`ifndef FLASH_SELFPROG_DEFS_VH
`define FLASH_SELFPROG_DEFS_VH

// =====================================================================
// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_KEY         8'h04
`define OFS_CTRL2       8'h08
`define OFS_ADDR_LOW    8'h0C
`define OFS_ADDR_HIGH   8'h10
`define OFS_DATA_LOW    8'h14
`define OFS_DATA_HIGH   8'h18
`define OFS_READ_DATA   8'h1C
`define OFS_IRQ_STATUS  8'h20
`define OFS_IRQ_MASK    8'h24

// =====================================================================
// Control field positions
`define CTRL_EW_ENABLED 7
`define CTRL_MODE_HI    6
`define CTRL_MODE_LO    4
`define CTRL_WRITE_PROT 3
`define CTRL_WRITE_GO   2
`define CTRL_READ_PERM  1
`define CTRL_READ_GO    0
`define CTRL2_ERASE_GO  1
`define CTRL2_CLEAR_BUF 0

// =====================================================================
// Erase/write enable key sequence, three writes in order
`define KEY_FIRST       8'h5A
`define KEY_SECOND      8'hA5
`define KEY_THIRD       8'h3C

// =====================================================================
// Interrupt event bits
`define EV_WRITE_DONE   0
`define EV_READ_DONE    1
`define EV_ERASE_DONE   2
`define EV_LOAD_REFUSED 3
`define EV_COUNT        4

// =====================================================================
// Flash array operation codes and reset values
`define OP_READ         2'h0
`define OP_WRITE        2'h1
`define OP_ERASE        2'h2
`define ERASED_WORD     16'hFFFF
`define RESET_BYTE      8'h00
`define WORD_OFS_LAST   5'h1F

`endif

/* logic/page_write_buffer.v */
// Page-sized write buffer held in flip-flops, with a walking clear.
// Assumes one clock domain; the caller never loads while clearing.
`include "flash_selfprog_defs.vh"

module page_write_buffer #(
   parameter WIDTH   = 16,
   parameter DEPTH   = 32,
   parameter IDX_W   = 5
) (
   input  wire             clk,
   input  wire             rst_b,
   input  wire             load,
   input  wire [IDX_W-1:0] load_idx,
   input  wire [WIDTH-1:0] load_data,
   input  wire             clear_start,
   input  wire [IDX_W-1:0] rd_idx,
   output wire [WIDTH-1:0] rd_data,
   output reg              clear_busy
);

   reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg  [IDX_W-1:0] clr_idx_q;
   genvar           g;

   // =================================================================
   // Storage; a clear walks one entry per cycle like the real array
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : g_entry
         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               mem_q[g] <= `ERASED_WORD;
            end else if (clear_busy && clr_idx_q == g[IDX_W-1:0]) begin
               mem_q[g] <= `ERASED_WORD;
            end else if (load && load_idx == g[IDX_W-1:0]) begin
               mem_q[g] <= load_data;
            end
         end
      end
   endgenerate

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clear_busy <= 1'b0;
         clr_idx_q  <= {IDX_W{1'b0}};
      end else if (clear_busy) begin
         clr_idx_q <= clr_idx_q + 1'b1;
         if (clr_idx_q == DEPTH[IDX_W-1:0] - 1'b1) begin
            clear_busy <= 1'b0;
         end
      end else if (clear_start) begin
         clear_busy <= 1'b1;
         clr_idx_q  <= {IDX_W{1'b0}};
      end
   end

   assign rd_data = mem_q[rd_idx];

endmodule // page_write_buffer

/* logic/event_irq.v */
// Sticky event flags, write-one-to-clear, with mask and level interrupt.
// Assumes events and clears arrive on the same clock.
`include "flash_selfprog_defs.vh"

module event_irq #(
   parameter N = 4
) (
   input  wire         clk,
   input  wire         rst_b,
   input  wire [N-1:0] event_set,
   input  wire [N-1:0] clear_ones,
   input  wire         mask_we,
   input  wire [N-1:0] mask_wdata,
   output reg  [N-1:0] status_q,
   output reg  [N-1:0] mask_q,
   output reg          irq_q
);

   wire [N-1:0] status_d;

   // A new event in the clearing cycle wins over the clear
   assign status_d = (status_q & ~clear_ones) | event_set;

   // =================================================================
   // Flags, mask and interrupt line
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_q <= {N{1'b0}};
         mask_q   <= {N{1'b0}};
         irq_q    <= 1'b0;
      end else begin
         status_q <= status_d;
         if (mask_we) begin
            mask_q <= mask_wdata;
         end
         irq_q <= |(status_d & (mask_we ? mask_wdata : mask_q));
      end
   end

endmodule // event_irq

/* test/flash_array_model.sv */
// Behavioural flash array on the far side of the controller.
// Assumes one request at a time; lat sets the answer delay in cycles.
`include "flash_selfprog_defs.vh"
module flash_array_model (
   input  wire         clk,
   input  wire         rst_b,
   input  wire         req,
   input  wire  [1:0]  op,
   input  wire  [12:0] addr,
   input  wire  [15:0] wdata,
   input  wire  [3:0]  lat,
   output logic        ack,
   output logic [15:0] rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [0:8191];
   logic [3:0]  cnt;
   int          j;
   initial foreach (mem[n]) mem[n] = 16'h0000;
   // Read data toggles outside the answer so stale words never look valid
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack <= 1'b0;
         cnt <= 4'h0;
         rdata <= 16'h0000;
      end else if (ack || !req) begin
         ack <= 1'b0;
         cnt <= 4'h0;
         rdata <= ~rdata;
      end else if (cnt >= lat) begin
         ack <= 1'b1;
         rdata <= mem[addr];
         if (op == `OP_WRITE) mem[addr] <= wdata;
         if (op == `OP_ERASE) begin
            for (j = 0; j < 32; j++) mem[{addr[12:5], j[4:0]}] <= `ERASED_WORD;
         end
      end else begin
         cnt <= cnt + 4'h1;
         rdata <= ~rdata;
      end
   end
endmodule // flash_array_model

/* test/flash_self_program_control_checker.sv */
// Port-level assertions for the flash self-programming controller.
// Assumes it is bound to the top module and sees only its ports.
`include "flash_selfprog_defs.vh"
module flash_self_program_control_checker #(
   parameter ADDR_W = 13
) (
   input wire              CORE_CLK,
   input wire              RST_B,
   input wire              PSEL,
   input wire              PENABLE,
   input wire [31:0]       PRDATA,
   input wire              PREADY,
   input wire              PSLVERR,
   input wire              FLASH_REQ,
   input wire [1:0]        FLASH_OP,
   input wire [ADDR_W-1:0] FLASH_ADDR,
   input wire              FLASH_ACK
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_B);
   // ==========================================================
   // Register bus
   setup_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("ready missing after setup");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready held past one cycle");
   idle_bus_a: assert property (!PREADY |-> PRDATA == 32'h0000_0000 && !PSLVERR)
      else $error("read data or error outside access");
   // ==========================================================
   // Flash link
   req_hold_a: assert property (
      FLASH_REQ && !FLASH_ACK |=> FLASH_REQ && $stable(FLASH_ADDR) && $stable(FLASH_OP))
      else $error("flash request changed before its answer");
   page_start_a: assert property (
      $rose(FLASH_REQ) && FLASH_OP != `OP_READ |-> FLASH_ADDR[4:0] == 5'h00)
      else $error("page operation not started at word zero");
   page_step_a: assert property (
      FLASH_ACK && FLASH_OP == `OP_WRITE && FLASH_ADDR[4:0] != `WORD_OFS_LAST
      |=> FLASH_REQ && FLASH_ADDR == $past(FLASH_ADDR) + 1'b1)
      else $error("page write did not step to the next word");
   page_end_a: assert property (
      FLASH_ACK && FLASH_OP == `OP_WRITE && FLASH_ADDR[4:0] == `WORD_OFS_LAST |=> !FLASH_REQ)
      else $error("page write ran past the last word");
   single_op_a: assert property (
      FLASH_ACK && FLASH_OP != `OP_WRITE |=> !FLASH_REQ)
      else $error("read or erase request outlived its answer");
endmodule // flash_self_program_control_checker

bind flash_self_program_control flash_self_program_control_checker #(
   .ADDR_W(ADDR_W)
) chk (
   .CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FLASH_REQ(FLASH_REQ),
   .FLASH_OP(FLASH_OP), .FLASH_ADDR(FLASH_ADDR), .FLASH_ACK(FLASH_ACK)
);

/* test/flash_self_program_control_test.sv */
// Self-checking bench for the flash self-programming controller.
// Assumes the flash array model beside it and the checker bound in.
`include "flash_selfprog_defs.vh"
module flash_self_program_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
   logic        req, ack, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [1:0]  op;
   logic [12:0] faddr;
   logic [15:0] wdata, rdata;
   logic [3:0]  lat;
   logic [7:0]  keys [0:6] = '{`KEY_FIRST, 8'h00, `KEY_SECOND, `KEY_THIRD,
                               `KEY_FIRST, `KEY_SECOND, `KEY_THIRD};
   int          n_errors, checks, k;
   flash_self_program_control dut (
      .CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .FLASH_REQ(req), .FLASH_OP(op), .FLASH_ADDR(faddr),
      .FLASH_WDATA(wdata), .FLASH_ACK(ack), .FLASH_RDATA(rdata), .IRQ(irq));
   flash_array_model mem (
      .clk(clk), .rst_b(rst_b), .req(req), .op(op), .addr(faddr), .wdata(wdata),
      .lat(lat), .ack(ack), .rdata(rdata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================================
   // Checking and bus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("Checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_errors++;
         final_report();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(q, exp);
   endtask
   // Start bits are cleared by hardware; a bounded poll waits for that
   task automatic poll(input logic [7:0] a, input logic [31:0] m);
      int i;
      i = 0;
      do begin
         apb(1'b0, a, 32'h0000_0000);
         i++;
      end while ((q & m) != 0 && i < 300);
      if (i >= 300) begin
         n_errors++;
         final_report();
      end
      check(q & m, 32'h0000_0000);
   endtask
   task automatic rdf(input logic [4:0] w, input logic [15:0] exp);
      wr(`OFS_ADDR_LOW, {24'h0, 3'h3, w});
      // The permit must already be stored when the start bit arrives
      wr(`OFS_CTRL, 32'h0000_0082);
      wr(`OFS_CTRL, 32'h0000_0083);
      poll(`OFS_CTRL, 32'h0000_0001);
      rd(`OFS_READ_DATA, {16'h0, exp});
   endtask
   // Buffer auto-clear after a write runs 32 cycles and blocks new starts
   task automatic page_program;
      wr(`OFS_CTRL, 32'h0000_0084);
      wr(`OFS_CTRL2, 32'h0000_0002);
      poll(`OFS_CTRL, 32'h0000_0004);
      repeat (40) @(posedge clk);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      lat = 4'h3;
      n_errors = 0;
      checks = 0;
      rst_b = 1'b0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rd(`OFS_CTRL, 32'h0000_0000);
      rd(`OFS_READ_DATA, 32'h0000_0000);
      rd(8'h28, 32'h0000_0000);
      check(e, 1'b1);
      wr(`OFS_DATA_LOW, 32'h0000_0034);
      wr(`OFS_DATA_HIGH, 32'h0000_0012);
      rd(`OFS_ADDR_LOW, 32'h0000_0000);
      wr(`OFS_IRQ_MASK, 32'h0000_000A);
      rd(`OFS_IRQ_STATUS, 32'h0000_0008);
      check(irq, 1'b1);
      wr(`OFS_IRQ_STATUS, 32'h0000_0008);
      rd(`OFS_ADDR_HIGH, 32'h0000_0000);
      check(irq, 1'b0);
      foreach (keys[i]) begin
         wr(`OFS_KEY, {24'h0, keys[i]});
         if (i == 3) rd(`OFS_CTRL, 32'h0000_0000);
      end
      rd(`OFS_CTRL, 32'h0000_0080);
      // Page 0xAB: high address 0x15 with low bits 7..5 at 3
      wr(`OFS_ADDR_HIGH, 32'h0000_0015);
      wr(`OFS_ADDR_LOW, 32'h0000_0060);
      wr(`OFS_CTRL2, 32'h0000_0002);
      poll(`OFS_CTRL2, 32'h0000_0002);
      wr(`OFS_IRQ_STATUS, 32'h0000_000F);
      rdf(5'd5, `ERASED_WORD);
      wr(`OFS_ADDR_LOW, 32'h0000_0060);
      wr(`OFS_CTRL2, 32'h0000_0001);
      poll(`OFS_CTRL2, 32'h0000_0001);
      for (k = 0; k < 33; k++) begin
         wr(`OFS_DATA_LOW, 32'(k));
         wr(`OFS_DATA_HIGH, 32'(k ^ 8'hA0));
         if (k == 0) rd(`OFS_ADDR_LOW, 32'h0000_0061);
      end
      rd(`OFS_ADDR_LOW, 32'h0000_007F);
      lat <= 4'h4;
      page_program();
      // Read done from the earlier read stays; no erase done as that start was refused
      rd(`OFS_IRQ_STATUS, 32'h0000_0003);
      wr(`OFS_IRQ_STATUS, 32'h0000_000F);
      lat <= 4'h0;
      rdf(5'd0, 16'hA000);
      rdf(5'd30, 16'hBE1E);
      rdf(5'd31, 16'h8020);
      check(irq, 1'b1);
      wr(`OFS_IRQ_STATUS, 32'h0000_0002);
      wr(`OFS_CTRL, 32'h0000_0081);
      rd(`OFS_ADDR_HIGH, 32'h0000_0015);
      rd(`OFS_IRQ_STATUS, 32'h0000_0000);
      check(irq, 1'b0);
      wr(`OFS_CTRL, 32'h0000_0080);
      page_program();
      rdf(5'd0, `ERASED_WORD);
      final_report();
   end
endmodule // flash_self_program_control_test
